// File: dpc_pkg.sv
// package for the dual-port ram port controller (host side)
// assumes one pclk domain; the controller drives one port of the ram
package dpc_pkg;
  // ====================================================================
  // apb register map of the controller
  localparam logic [7:0] DPC_REG_CTRL = 8'h00; // command and go
  localparam logic [7:0] DPC_REG_ADDR = 8'h04; // ram or semaphore address
  localparam logic [7:0] DPC_REG_WDATA = 8'h08; // write data
  localparam logic [7:0] DPC_REG_RDATA = 8'h0c; // last read data
  localparam logic [7:0] DPC_REG_STAT = 8'h10; // status
  localparam logic [7:0] DPC_REG_CFG = 8'h14; // strobe timing, mode
  // ====================================================================
  // ctrl fields
  localparam int DPC_CTRL_GO = 0; // write 1 to start
  localparam int DPC_CTRL_WR = 1; // 1 write, 0 read
  localparam int DPC_CTRL_SEM = 2; // 1 semaphore latch access
  localparam int DPC_CTRL_HB = 3; // enable high byte (ram)
  localparam int DPC_CTRL_LB = 4; // enable low byte (ram)
  // status fields
  localparam int DPC_STAT_BUSY = 0; // command running
  localparam int DPC_STAT_DONE = 1; // sticky done
  localparam int DPC_STAT_INT = 2; // mailbox flag seen low
  localparam int DPC_STAT_BSY = 3; // busy pin seen low
  localparam int DPC_STAT_SEMOWN = 4; // last semaphore read was zero
  // cfg fields: strobe length [7:0], gap length [15:8], master [16]
  localparam int DPC_CFG_MS = 16;
  localparam logic [31:0] DPC_CFG_RST = 32'h0001_0404;
  // ====================================================================
  // timing: semaphore gap before the verifying read
  localparam int DPC_SEM_GAP_NS = 10; // semaphore_gap_time
  localparam int DPC_CLK_NS = 5;
  localparam int DPC_SEM_GAP_CYC =
    (DPC_SEM_GAP_NS + DPC_CLK_NS - 1) / DPC_CLK_NS;
  localparam logic [15:0] DPC_DATA_ONE = 16'h0001;
  localparam logic [15:0] DPC_DATA_ZERO = 16'h0000;
  // sequencer states, gray along idle -> strobe -> hold -> gap
  typedef enum logic [1:0] {
    DPC_IDLE = 2'b00,
    DPC_STRB = 2'b01,
    DPC_HOLD = 2'b11,
    DPC_GAP = 2'b10
  } dpc_state_type;
endpackage

// File: dpc_apb_regs.sv
// apb slave holding the controller's own registers
// assumes zero-wait apb: pready high in every access phase
`timescale 1ns/1ps
module dpc_apb_regs
  import dpc_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // to and from the sequencer
  output logic go_pulse,
  output logic [4:0] ctrl_q,
  output logic [15:0] addr_q,
  output logic [15:0] wdata_q,
  output logic [31:0] cfg_q,
  input wire logic [15:0] rdata,
  input wire logic [4:0] stat,
  output logic done_clr
);
  import dpc_pkg::*;
  // ====================================================================
  // decode
  wire logic acc = psel && penable;
  wire logic wr_en = acc && pwrite;
  wire logic hit_ctrl = paddr == DPC_REG_CTRL;
  wire logic hit_addr = paddr == DPC_REG_ADDR;
  wire logic hit_wd = paddr == DPC_REG_WDATA;
  wire logic hit_rd = paddr == DPC_REG_RDATA;
  wire logic hit_st = paddr == DPC_REG_STAT;
  wire logic hit_cfg = paddr == DPC_REG_CFG;
  wire logic mapped = hit_ctrl | hit_addr | hit_wd | hit_rd | hit_st |
    hit_cfg;
  assign pready = 1'b1;
  // unmapped addresses answer with an error, reads give zero
  assign pslverr = acc && !mapped;
  // go is delayed one cycle so that ctrl_q already holds the new command
  // when the sequencer latches it; a same-edge latch would take the old one
  logic go_q;
  assign go_pulse = go_q;
  // writing the status word with done set clears the sticky done
  assign done_clr = wr_en && hit_st && pwdata[DPC_STAT_DONE];
  assign prdata = hit_ctrl ? {27'h0, ctrl_q} :
    hit_addr ? {16'h0, addr_q} :
    hit_wd ? {16'h0, wdata_q} :
    hit_rd ? {16'h0, rdata} :
    hit_st ? {27'h0, stat} :
    hit_cfg ? cfg_q : 32'h0;
  // ====================================================================
  // storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 5'h00;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      cfg_q <= DPC_CFG_RST;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_q <= {pwdata[4:1], 1'b0};
      if (hit_addr) addr_q <= pwdata[15:0];
      if (hit_wd) wdata_q <= pwdata[15:0];
      if (hit_cfg) cfg_q <= pwdata;
    end
  end
  // one-cycle go strobe, follows the ctrl write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q <= 1'b0;
    end else begin
      go_q <= wr_en && hit_ctrl && pwdata[DPC_CTRL_GO];
    end
  end
endmodule

// File: dpc_port_ctrl.sv
// one-port controller for an asynchronous dual-port ram with semaphores
// assumes the ram pins are sampled synchronously to pclk
`timescale 1ns/1ps
module dpc_port_ctrl
  import dpc_pkg::*;
#(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 16
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ram port pins
  output logic chip_en_n,
  output logic rw_n,
  output logic out_en_n,
  output logic latch_bank_select_n,
  output logic high_byte_select_n,
  output logic low_byte_select_n,
  output logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic int_n,
  input wire logic busy_n,
  output logic master_sel
);
  import dpc_pkg::*;
  // ====================================================================
  // register file
  logic go;
  logic [4:0] ctrl;
  logic [15:0] a_reg;
  logic [15:0] wd_reg;
  logic [31:0] cfg;
  logic [4:0] stat;
  logic dclr;
  logic [DATA_W-1:0] rdata_q; // captured read data
  logic [DATA_W-1:0] rdata_d;
  dpc_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .go_pulse(go),
    .ctrl_q(ctrl),
    .addr_q(a_reg),
    .wdata_q(wd_reg),
    .cfg_q(cfg),
    .rdata(rdata_q[15:0]),
    .stat(stat),
    .done_clr(dclr)
  );
  // ====================================================================
  // sequencer state
  dpc_state_type state_q, state_d;
  logic [7:0] cnt_q, cnt_d; // cycles left in current phase
  logic done_q, done_d; // sticky completion
  logic own_q, own_d; // last semaphore read gave zero
  logic wr_q, sem_q, hb_q, lb_q; // latched command
  logic lat_en;
  wire logic [7:0] strobe_len = cfg[7:0];
  wire logic [7:0] gap_cfg = cfg[15:8];
  // gap is never below the semaphore gap time
  wire logic [7:0] gap_len = (gap_cfg < 8'(DPC_SEM_GAP_CYC)) ?
    8'(DPC_SEM_GAP_CYC) : gap_cfg;
  // master when cfg bit set: our busy_n is then the device's output
  assign master_sel = cfg[DPC_CFG_MS];
  // any write, master or slave, is held while busy is asserted; the master's busy
  // line reaches us by board wiring only
  wire logic hold_wr = wr_q && !busy_n;
  wire logic strb = (state_q == DPC_STRB) || (state_q == DPC_HOLD);
  // ====================================================================
  // pin decode: semaphore access keeps chip enable and bytes high
  assign chip_en_n = !(strb && !sem_q);
  assign latch_bank_select_n = !(strb && sem_q);
  // byte lanes only in ram accesses; both high on semaphore ops
  assign high_byte_select_n = !(strb && !sem_q && hb_q);
  assign low_byte_select_n = !(strb && !sem_q && lb_q);
  assign rw_n = !(strb && wr_q && !hold_wr);
  assign out_en_n = !(strb && !wr_q);
  // only the low three bits matter for semaphores; send them clean
  assign addr = sem_q ? ADDR_W'(a_reg[2:0]) : a_reg[ADDR_W-1:0];
  // semaphore write: value on bit zero, 0 claims, 1 releases
  assign data_o = sem_q ? {{(DATA_W-1){1'b0}}, wd_reg[0]} :
    wd_reg[DATA_W-1:0];
  assign data_oe = strb && wr_q;
  // flag and busy are reported active high, inverted from the device pins
  assign stat = {own_q, !busy_n, !int_n, done_q,
    state_q != DPC_IDLE};
  // ====================================================================
  // next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = done_q;
    lat_en = 1'b0;
    unique case (state_q)
      DPC_IDLE: begin
        if (go) begin
          lat_en = 1'b1;
          cnt_d = strobe_len;
          state_d = DPC_STRB;
        end
      end
      DPC_STRB: begin
        // strobe counts only while not held off by busy
        if (hold_wr) begin
          cnt_d = cnt_q;
        end else if (cnt_q == 8'h00) begin
          state_d = DPC_HOLD;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      DPC_HOLD: begin
        // read data sampled here, then release strobes
        cnt_d = gap_len;
        state_d = DPC_GAP;
      end
      DPC_GAP: begin
        // deselected gap before any next access
        if (cnt_q == 8'h00) begin
          state_d = DPC_IDLE;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
    endcase
    // set wins over clear
    if (dclr && !(state_q == DPC_GAP && cnt_q == 8'h00)) done_d = 1'b0;
  end
  // read capture: semaphore value is on every line, use bit zero
  always_comb begin
    rdata_d = rdata_q;
    own_d = own_q;
    if (state_q == DPC_HOLD && !wr_q) begin
      rdata_d = data_i;
      if (sem_q) own_d = !data_i[0];
    end
  end
  // ====================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DPC_IDLE;
      cnt_q <= 8'h00;
      done_q <= 1'b0;
      own_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      own_q <= own_d;
      rdata_q <= rdata_d;
    end
  end
  // command latch, taken at go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 1'b0;
      sem_q <= 1'b0;
      hb_q <= 1'b0;
      lb_q <= 1'b0;
    end else if (lat_en) begin
      wr_q <= ctrl[DPC_CTRL_WR];
      sem_q <= ctrl[DPC_CTRL_SEM];
      hb_q <= ctrl[DPC_CTRL_HB];
      lb_q <= ctrl[DPC_CTRL_LB];
    end
  end
  // mailbox: a write to the far port's mailbox sets its flag, a read of
  // our own mailbox clears ours; both addresses are plain ram accesses
endmodule

// File: dpc_port_ctrl_sva.sv
// pin checker for the ram port controller
// assumes binding into dpc_port_ctrl, one pclk domain
`timescale 1ns/1ps
module dpc_port_ctrl_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // ram pins
  input wire logic chip_en_n,
  input wire logic rw_n,
  input wire logic out_en_n,
  input wire logic latch_bank_select_n,
  input wire logic high_byte_select_n,
  input wire logic low_byte_select_n,
  input wire logic data_oe,
  input wire logic busy_n,
  input wire logic master_sel
);
  // ==============================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SEM_CE_OFF: assert property (
    !latch_bank_select_n |-> chip_en_n) else $error("ce in sem");
  AST_SEM_LANES_OFF: assert property (
    !latch_bank_select_n |-> high_byte_select_n && low_byte_select_n)
    else $error("lanes in sem");
  AST_NO_MIXED_SEL: assert property (
    !chip_en_n && !(high_byte_select_n && low_byte_select_n)
    |-> latch_bank_select_n) else $error("mixed select");
  AST_SEM_GAP: assert property (
    $rose(latch_bank_select_n) |-> latch_bank_select_n [*2])
    else $error("sem gap short");
  AST_WR_DRIVES: assert property (
    !rw_n && !latch_bank_select_n |-> data_oe) else $error("no drive");
  AST_RD_NO_DRIVE: assert property (
    !out_en_n |-> rw_n && !data_oe) else $error("drive in read");
  AST_SLAVE_WAIT: assert property (
    !rw_n && !master_sel |-> busy_n)
    else $error("slave write in busy");
  AST_SEM_HOLD: assert property (
    $fell(latch_bank_select_n) |=> (!latch_bank_select_n &&
    $stable(rw_n)) [*5]) else $error("sem strobe short");
endmodule

// File: dpc_ram_model.sv
// behavioural model of one ram port with semaphores and mailboxes
// assumes the far port is played by calls to sem_op and far_write
`timescale 1ns/1ps
module dpc_ram_model (
  // pins from the controller
  input wire logic chip_en_n,
  input wire logic rw_n,
  input wire logic out_en_n,
  input wire logic latch_bank_select_n,
  input wire logic high_byte_select_n,
  input wire logic low_byte_select_n,
  input wire logic [12:0] addr,
  input wire logic [15:0] data_o,
  // answers
  output logic [15:0] data_i,
  output logic int_n = 1'b1,
  output logic busy_n = 1'b1
);
  // ==============================
  // storage
  logic [15:0] mem [0:8191];
  logic [7:0] own [2] = '{8'h00, 8'h00}; // all free at start
  logic [7:0] req [2] = '{8'h00, 8'h00}; // queued claims
  logic far_int_n = 1'b1;
  logic [12:0] wa;
  logic [15:0] wd, rq = 16'h0000;
  logic ws, whb, wlb, rhb, rlb;
  wire sel = !latch_bank_select_n || !chip_en_n;
  wire wr_on = sel && !rw_n;
  wire rd_on = sel && rw_n && !out_en_n;
  // owner alone releases; a queued claim inherits at once
  task automatic sem_op(input bit s, input int i, input bit v);
    if (!v && !own[0][i] && !own[1][i]) own[s][i] = 1'b1;
    else if (!v) req[s][i] = !own[s][i];
    else if (own[s][i]) begin
      own[s][i] = 1'b0;
      own[!s][i] = req[!s][i];
      req[!s][i] = 1'b0;
    end else req[s][i] = 1'b0;
  endtask
  task automatic far_write(input logic [12:0] a, input logic [15:0] d);
    mem[a] = d;
    if (a == 13'h1ffe) int_n = 1'b0;
  endtask
  // hold the target while the strobe is low, land it at the end
  // pins settle a moment after the strobe opens; take the target then,
  // so that the closing edge cannot race the capture
  always @(posedge wr_on) begin
    #1;
    {ws, wa, wd, whb, wlb} = {!latch_bank_select_n, addr, data_o,
      !high_byte_select_n, !low_byte_select_n};
  end
  always @(negedge wr_on) begin
    if (ws) sem_op(1'b0, wa[2:0], wd[0]);
    else begin
      if (whb) mem[wa][15:8] = wd[15:8];
      if (wlb) mem[wa][7:0] = wd[7:0];
      if (wa == 13'h1fff && busy_n) far_int_n = 1'b0;
    end
  end
  // read value frozen for the whole read
  always @(posedge rd_on) begin
    #1;
    rq = latch_bank_select_n ? mem[addr] : {16{!own[0][addr[2:0]]}};
    rhb = !latch_bank_select_n || !high_byte_select_n;
    rlb = !latch_bank_select_n || !low_byte_select_n;
    if (latch_bank_select_n && addr == 13'h1ffe && busy_n)
      int_n = 1'b1;
  end
  // released lanes show the inverse, never a held value
  always @* begin
    data_i = ~rq;
    if (rd_on && rhb) data_i[15:8] = rq[15:8];
    if (rd_on && rlb) data_i[7:0] = rq[7:0];
  end
endmodule

// File: tb_top.sv
// self-checking bench for the ram port controller
// assumes the port model answers on the pins, pclk at 200 MHz
`timescale 1ns/1ps
module tb_top;
  import dpc_pkg::*;
  // ==============================
  // signals and instances
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic chip_en_n, rw_n, out_en_n, latch_bank_select_n, data_oe;
  logic high_byte_select_n, low_byte_select_n, master_sel, int_n, busy_n;
  logic [12:0] addr;
  logic [15:0] data_i, data_o;
  int fail_count = 0, checks_done = 0;
  // go plus kind of access
  localparam logic [4:0] sem_wr = 5'h07, sem_rd = 5'h05, hi_wr = 5'h0b;
  localparam logic [4:0] ram_wr = 5'h1b, ram_rd = 5'h19;
  always #2.5 pclk = ~pclk;
  dpc_port_ctrl u_dut (.*);
  dpc_ram_model u_ram (.*);
  // ==============================
  // tasks
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      $display("unexpected %s: expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done();
    do apb(1'b0, DPC_REG_STAT, 32'h0); while (rd[DPC_STAT_DONE] !== 1'b1);
    apb(1'b1, DPC_REG_STAT, 32'h2);
    apb(1'b0, DPC_REG_RDATA, 32'h0);
  endtask
  task automatic op(input logic [4:0] c, input logic [15:0] a, d,
    input bit w = 1'b1);
    apb(1'b1, DPC_REG_ADDR, {16'h0000, a});
    apb(1'b1, DPC_REG_WDATA, {16'h0000, d});
    apb(1'b1, DPC_REG_CTRL, {27'h0, c});
    if (w) wait_done();
  endtask
  task automatic rchk(input string n, input logic [4:0] c,
    input logic [15:0] a, e);
    op(c, a, 16'h0000);
    chk(n, rd[15:0], e);
  endtask
  // ==============================
  // tests
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, DPC_REG_CFG, 32'h0);
    chk("cfg", rd, DPC_CFG_RST);
    chk("master", master_sel, 1'b1);
    rchk("free", sem_rd, 16'h0003, 16'hffff);
    op(sem_wr, 16'h1ffb, 16'h0000);
    rchk("claim", sem_rd, 16'h0003, 16'h0000);
    u_ram.sem_op(1'b1, 3, 1'b0);
    rchk("kept", sem_rd, 16'h0003, 16'h0000);
    op(sem_wr, 16'h0003, 16'h0001);
    rchk("passed", sem_rd, 16'h0003, 16'hffff);
    u_ram.sem_op(1'b1, 3, 1'b1);
    op(sem_wr, 16'h0005, 16'hfffe);
    rchk("bit0", sem_rd, 16'h0005, 16'h0000);
    op(sem_wr, 16'h0005, 16'h0001);
    $display("test semaphore done");
    op(ram_wr, 16'h0010, 16'habcd);
    op(hi_wr, 16'h0010, 16'h12ff);
    rchk("lanes", ram_rd, 16'h0010, 16'h12cd);
    u_ram.far_write(13'h1ffe, 16'h5a5a);
    apb(1'b0, DPC_REG_STAT, 32'h0);
    chk("int seen", rd[DPC_STAT_INT], 1'b1);
    u_ram.busy_n <= 1'b0;
    op(ram_rd, 16'h1ffe, 16'h0000);
    chk("int busy", int_n, 1'b0);
    u_ram.busy_n <= 1'b1;
    op(ram_rd, 16'h1fff, 16'h0000);
    chk("int other", int_n, 1'b0);
    rchk("mailbox", ram_rd, 16'h1ffe, 16'h5a5a);
    chk("int clr", int_n, 1'b1);
    op(ram_wr, 16'h1fff, 16'h0001);
    chk("far int", u_ram.far_int_n, 1'b0);
    $display("test ram done");
    apb(1'b1, DPC_REG_CFG, 32'h0000_0404);
    @(negedge pclk);
    chk("slave", master_sel, 1'b0);
    u_ram.busy_n <= 1'b0;
    op(ram_wr, 16'h0020, 16'h7777, 1'b0);
    repeat (20) @(posedge pclk);
    apb(1'b0, DPC_REG_STAT, 32'h0);
    chk("stalled", rd[DPC_STAT_DONE], 1'b0);
    chk("held", rw_n, 1'b1);
    u_ram.busy_n <= 1'b1;
    wait_done();
    rchk("slave data", ram_rd, 16'h0020, 16'h7777);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", err, 1'b1);
    chk("slverr data", rd, 32'h0);
    $display("test slave done");
    summarize();
  end
  // watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    summarize();
  end
endmodule
bind dpc_port_ctrl dpc_port_ctrl_sva u_sva (
  .pclk(pclk),
  .presetn(presetn),
  .chip_en_n(chip_en_n),
  .rw_n(rw_n),
  .out_en_n(out_en_n),
  .latch_bank_select_n(latch_bank_select_n),
  .high_byte_select_n(high_byte_select_n),
  .low_byte_select_n(low_byte_select_n),
  .data_oe(data_oe),
  .busy_n(busy_n),
  .master_sel(master_sel)
);
